// ==== design/cfm_clock_fault_monitor.v ====
`timescale 1ns/10ps
`default_nettype none
`include "cfm_consts.vh"

module cfm_clock_fault_monitor #(
  parameter        NAL      = 4,
  parameter [31:0] LL_WIN   = `CFM_LL_WIN,
  parameter [31:0] VAL0_CYC = `CFM_VAL0_US * `CFM_CLK_MHZ,
  parameter [31:0] VAL1_CYC = `CFM_VAL1_US * `CFM_CLK_MHZ,
  parameter [31:0] VAL2_CYC = `CFM_VAL2_US * `CFM_CLK_MHZ,
  parameter [31:0] VAL3_CYC = `CFM_VAL3_US * `CFM_CLK_MHZ
)(
  input  wire            clock_i,
  input  wire            rst_i,
  input  wire            psel_i,
  input  wire            penable_i,
  input  wire            pwrite_i,
  input  wire [7:0]      paddr_i,
  input  wire [31:0]     pwdata_i,
  output wire [31:0]     prdata_o,
  output wire            pready_o,
  output wire            pslverr_o,
  input  wire [3:0]      clock_input_i,
  input  wire [3:0]      pll_ref_i,
  input  wire [3:0]      pll_fb_i,
  output wire [3:0]      clock_loss_flag_o,
  output wire [3:0]      lock_loss_flag_o,
  output wire [NAL-1:0]  alarm_pin_o,
  output wire            interrupt_out_n_o,
  output wire            irq_o
);

  localparam [63:0] LL_WIN64 = {32'h0000_0000, LL_WIN};
  localparam [63:0] PPM_DIV  = 64'h0000_0000_0098_9680;

  // ----------------------------------------------------------------------
  // Register file state
  // ----------------------------------------------------------------------
  reg  [7:0]       nfy_q;
  reg  [7:0]       nfy_en_q;
  reg  [7:0]       int_sel_q;
  reg  [7:0]       irq_st_q;
  reg  [7:0]       irq_mask_q;
  reg  [127:0]     cl_cfg_q;
  reg  [127:0]     ll_cfg_q;
  reg  [32*NAL-1:0] al_cfg_q;
  reg  [31:0]      rdata_q;
  reg              rerr_q;
  reg  [7:0]       live_prev_q;
  reg  [NAL-1:0]   alarm_q;
  reg              int_n_q;
  reg              irq_q;
  reg  [31:0]      rdata_d;
  reg              rhit_d;

  wire [3:0]       cl_live;
  wire [3:0]       ll_live;
  wire [7:0]       live = {ll_live, cl_live};
  wire             setup_ph  = psel_i & ~penable_i;
  wire             access_ph = psel_i & penable_i;
  wire             wr_acc    = access_ph & pwrite_i;
  wire             rd_acc    = access_ph & ~pwrite_i;
  wire [1:0]       idx       = paddr_i[3:2];

  // ----------------------------------------------------------------------
  // Threshold table, ppm in tenths scaled to the window length
  // ----------------------------------------------------------------------
  // The window must reach 5e6 edges before 0.2 ppm is one count, so the
  // product is widened to 64 bits before the division.
  function [31:0] cfm_thr;
    input [4:0] sel;
    reg   [63:0] ppm10;
    reg   [63:0] prod;
    begin
      case (sel)
        5'd0:    ppm10 = 64'h0000_0000_0000_0002;
        5'd1:    ppm10 = 64'h0000_0000_0000_0004;
        5'd2:    ppm10 = 64'h0000_0000_0000_0014;
        5'd3:    ppm10 = 64'h0000_0000_0000_0028;
        5'd4:    ppm10 = 64'h0000_0000_0000_00C8;
        5'd5:    ppm10 = 64'h0000_0000_0000_0190;
        5'd6:    ppm10 = 64'h0000_0000_0000_07D0;
        5'd7:    ppm10 = 64'h0000_0000_0000_0FA0;
        5'd8:    ppm10 = 64'h0000_0000_0000_4E20;
        5'd16:   ppm10 = 64'h0000_0000_0000_0002;
        5'd17:   ppm10 = 64'h0000_0000_0000_0004;
        5'd18:   ppm10 = 64'h0000_0000_0000_0014;
        5'd19:   ppm10 = 64'h0000_0000_0000_07D0;
        default: ppm10 = 64'h0000_0000_0000_9C40;
      endcase
      prod    = (ppm10 * LL_WIN64) / PPM_DIV;
      cfm_thr = prod[31:0];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Clock-loss monitors
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_cl
      reg  [15:0] gap_q;
      reg  [3:0]  miss_q;
      reg         lost_q;
      reg  [31:0] val_q;
      reg         in_q;
      reg  [31:0] lim;
      wire        edge_s = clock_input_i[g] ^ in_q;
      wire [15:0] per    = cl_cfg_q[32*g+`CFM_CL_PER_LSB +: 16];
      wire [3:0]  trig   = cl_cfg_q[32*g+`CFM_CL_TRIG_LSB +: 4];
      wire [3:0]  clr    = cl_cfg_q[32*g+`CFM_CL_CLR_LSB +: 4];
      wire [1:0]  vsel   = cl_cfg_q[32*g+`CFM_CL_VAL_LSB +: 2];

      always @*
      begin
        case (vsel)
          2'd0:    lim = VAL0_CYC;
          2'd1:    lim = VAL1_CYC;
          2'd2:    lim = VAL2_CYC;
          default: lim = VAL3_CYC;
        endcase
      end

      always @(posedge clock_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          in_q   <= 1'b0;
          gap_q  <= 16'h0000;
          miss_q <= 4'h0;
          lost_q <= 1'b0;
          val_q  <= 32'h0000_0000;
        end
        else
        begin
          in_q <= clock_input_i[g];
          // A missing edge is one expected period with no transition.
          if (edge_s)
          begin
            gap_q  <= 16'h0000;
            miss_q <= 4'h0;
          end
          else if (gap_q >= per)
          begin
            gap_q <= 16'h0000;
            if (miss_q != 4'hF)
              miss_q <= miss_q + 4'h1;
          end
          else
            gap_q <= gap_q + 16'h0001;

          if (!lost_q)
          begin
            val_q <= 32'h0000_0000;
            if (miss_q >= trig && miss_q != 4'h0)
              lost_q <= 1'b1;
          end
          else if (miss_q >= clr)
            val_q <= 32'h0000_0000;
          else if (val_q + 32'h0000_0001 >= lim)
            lost_q <= 1'b0;
          else
            val_q <= val_q + 32'h0000_0001;
        end
      end

      assign cl_live[g] = lost_q;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Lock-loss monitors
  // ----------------------------------------------------------------------
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_ll
      reg  [31:0] rcnt_q;
      reg  [31:0] fcnt_q;
      reg         rp_q;
      reg         fp_q;
      reg         ll_q;
      reg         settling_q;
      reg  [23:0] stl_q;
      wire        redge  = pll_ref_i[g] & ~rp_q;
      wire        fedge  = pll_fb_i[g] & ~fp_q;
      wire        wend   = redge & (rcnt_q + 32'h0000_0001 >= LL_WIN);
      wire [31:0] ftot   = fcnt_q + {31'h0000_0000, fedge};
      wire [31:0] diff   = (ftot > LL_WIN) ? ftot - LL_WIN : LL_WIN - ftot;
      wire [3:0]  ssel   = ll_cfg_q[32*g+`CFM_LL_SET_LSB +: 4];
      wire [1:0]  csel   = ll_cfg_q[32*g+`CFM_LL_CLR_LSB +: 2];
      wire [23:0] settle = ll_cfg_q[32*g+`CFM_LL_SETL_LSB +: 24];
      wire [31:0] set_thr = cfm_thr({1'b0, ssel});
      wire [31:0] clr_thr = cfm_thr({3'b100, csel});

      always @(posedge clock_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          rcnt_q     <= 32'h0000_0000;
          fcnt_q     <= 32'h0000_0000;
          rp_q       <= 1'b0;
          fp_q       <= 1'b0;
          ll_q       <= 1'b0;
          settling_q <= 1'b0;
          stl_q      <= 24'h00_0000;
        end
        else
        begin
          rp_q <= pll_ref_i[g];
          fp_q <= pll_fb_i[g];
          if (wend)
          begin
            rcnt_q <= 32'h0000_0000;
            fcnt_q <= 32'h0000_0000;
          end
          else
          begin
            rcnt_q <= rcnt_q + {31'h0000_0000, redge};
            fcnt_q <= ftot;
          end

          if (!ll_q)
          begin
            settling_q <= 1'b0;
            stl_q      <= 24'h00_0000;
            if (wend && diff > set_thr)
              ll_q <= 1'b1;
          end
          else if (wend && diff > clr_thr)
          begin
            settling_q <= 1'b0;
            stl_q      <= 24'h00_0000;
          end
          else if (settling_q)
          begin
            if (stl_q >= settle)
            begin
              ll_q       <= 1'b0;
              settling_q <= 1'b0;
            end
            else
              stl_q <= stl_q + 24'h00_0001;
          end
          else if (wend)
            settling_q <= 1'b1;
        end
      end

      assign ll_live[g] = ll_q;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always @*
  begin
    rdata_d = 32'h0000_0000;
    rhit_d  = 1'b1;
    if (paddr_i == `CFM_OFF_STATUS)
      rdata_d[7:0] = live;
    else if (paddr_i == `CFM_OFF_NOTIFY)
      rdata_d[7:0] = nfy_q;
    else if (paddr_i == `CFM_OFF_NFY_EN)
      rdata_d[7:0] = nfy_en_q;
    else if (paddr_i == `CFM_OFF_INT_SEL)
      rdata_d[7:0] = int_sel_q;
    else if (paddr_i == `CFM_OFF_IRQ_ST)
      rdata_d[7:0] = irq_st_q;
    else if (paddr_i == `CFM_OFF_IRQ_MASK)
      rdata_d[7:0] = irq_mask_q;
    else if (paddr_i[7:4] == 4'h2 && paddr_i[1:0] == 2'b00)
      rdata_d = cl_cfg_q[32*idx +: 32];
    else if (paddr_i[7:4] == 4'h3 && paddr_i[1:0] == 2'b00)
      rdata_d = ll_cfg_q[32*idx +: 32];
    else if (paddr_i[7:4] == 4'h4 && paddr_i[1:0] == 2'b00 && idx < NAL)
      rdata_d = al_cfg_q[32*idx +: 32];
    else
      rhit_d = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Register writes, notify and interrupt logic
  // ----------------------------------------------------------------------
  // Read data is captured in the setup cycle so the access phase can
  // complete at once; an irq read clears only the bits it returned, so
  // events landing during the access are kept.
  integer a;
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      nfy_q       <= 8'h00;
      nfy_en_q    <= `CFM_NFY_EN_RST;
      int_sel_q   <= `CFM_INT_SEL_RST;
      irq_st_q    <= 8'h00;
      irq_mask_q  <= `CFM_IRQ_MASK_RST;
      cl_cfg_q    <= {4{`CFM_CL_CFG_RST}};
      ll_cfg_q    <= {4{`CFM_LL_CFG_RST}};
      al_cfg_q    <= {NAL{`CFM_ALARM_CFG_RST}};
      rdata_q     <= 32'h0000_0000;
      rerr_q      <= 1'b0;
      live_prev_q <= 8'h00;
      alarm_q     <= {NAL{1'b0}};
      int_n_q     <= 1'b1;
      irq_q       <= 1'b0;
    end
    else
    begin
      if (setup_ph)
      begin
        rdata_q <= rdata_d;
        rerr_q  <= ~rhit_d;
      end
      live_prev_q <= live;

      // Set wins over a clear; a clear of a live defect is refused.
      nfy_q <= (nfy_q & ~(((wr_acc && paddr_i == `CFM_OFF_NOTIFY) ?
                 pwdata_i[7:0] : 8'h00) & ~live))
               | (live & nfy_en_q);
      irq_st_q <= (irq_st_q & ~((rd_acc && paddr_i == `CFM_OFF_IRQ_ST) ?
                    rdata_q[7:0] : 8'h00))
                  | (live & ~live_prev_q);

      if (wr_acc)
      begin
        if (paddr_i == `CFM_OFF_NFY_EN)
          nfy_en_q <= pwdata_i[7:0];
        else if (paddr_i == `CFM_OFF_INT_SEL)
          int_sel_q <= pwdata_i[7:0];
        else if (paddr_i == `CFM_OFF_IRQ_MASK)
          irq_mask_q <= pwdata_i[7:0];
        else if (paddr_i[7:4] == 4'h2 && paddr_i[1:0] == 2'b00)
          cl_cfg_q[32*idx +: 32] <= pwdata_i;
        else if (paddr_i[7:4] == 4'h3 && paddr_i[1:0] == 2'b00)
          ll_cfg_q[32*idx +: 32] <= pwdata_i;
        else if (paddr_i[7:4] == 4'h4 && paddr_i[1:0] == 2'b00 && idx < NAL)
          al_cfg_q[32*idx +: 32] <= pwdata_i;
      end

      for (a = 0; a < NAL; a = a + 1)
        alarm_q[a] <= |(nfy_q & al_cfg_q[32*a +: 8]);
      int_n_q <= ~|(nfy_q & int_sel_q);
      irq_q   <= |(irq_st_q & irq_mask_q);
    end
  end

  assign prdata_o          = rdata_q;
  assign pready_o          = 1'b1;
  assign pslverr_o         = access_ph & rerr_q;
  assign clock_loss_flag_o = cl_live;
  assign lock_loss_flag_o  = ll_live;
  assign alarm_pin_o       = alarm_q;
  assign interrupt_out_n_o = int_n_q;
  assign irq_o             = irq_q;

endmodule
`default_nettype wire

// ==== design/cfm_consts.vh ====
`ifndef CFM_CONSTS_VH
`define CFM_CONSTS_VH

// ----------------------------------------------------------------------
// Clock rate and validation times
// ----------------------------------------------------------------------
`define CFM_CLK_MHZ        25
`define CFM_VAL0_US        2000
`define CFM_VAL1_US        100000
`define CFM_VAL2_US        200000
`define CFM_VAL3_US        1000000

// ----------------------------------------------------------------------
// Lock-loss measurement window, in reference edges
// ----------------------------------------------------------------------
`define CFM_LL_WIN         5000000

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CFM_OFF_STATUS     8'h00
`define CFM_OFF_NOTIFY     8'h04
`define CFM_OFF_NFY_EN     8'h08
`define CFM_OFF_INT_SEL    8'h0C
`define CFM_OFF_IRQ_ST     8'h10
`define CFM_OFF_IRQ_MASK   8'h14
`define CFM_OFF_CL_CFG     8'h20
`define CFM_OFF_LL_CFG     8'h30
`define CFM_OFF_ALARM_CFG  8'h40
`define CFM_OFF_END        8'h50

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CFM_CL_PER_LSB     0
`define CFM_CL_TRIG_LSB    16
`define CFM_CL_CLR_LSB     20
`define CFM_CL_VAL_LSB     24
`define CFM_LL_SET_LSB     0
`define CFM_LL_CLR_LSB     4
`define CFM_LL_SETL_LSB    8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CFM_CL_CFG_RST     32'h0024_0040
`define CFM_LL_CFG_RST     32'h0010_0036
`define CFM_ALARM_CFG_RST  32'h0000_0000
`define CFM_NFY_EN_RST     8'hFF
`define CFM_INT_SEL_RST    8'h00
`define CFM_IRQ_MASK_RST   8'h00

`endif

// ==== testbench/cfm_far_side.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Clock sources seen after the input divider, and PLL ref/feedback
// ----------------------------------------------------------------------
module cfm_far_side (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] run_i,
  input  wire logic [3:0] fb_run_i,
  output logic      [3:0] clock_input_o,
  output logic      [3:0] ref_o,
  output logic      [3:0] fb_o
);
  logic [7:0] div_q;

  // A stopped source holds its last level, as a dead clock line does.
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_q         <= 8'h00;
      clock_input_o <= 4'h0;
      ref_o         <= 4'h0;
      fb_o          <= 4'h0;
    end
    else
    begin
      div_q         <= div_q + 8'h01;
      clock_input_o <= (div_q[3:0] & run_i) | (clock_input_o & ~run_i);
      ref_o         <= ~ref_o;
      fb_o          <= (~ref_o & fb_run_i) | (fb_o & ~fb_run_i);
    end
  end
endmodule
`default_nettype wire

// ==== testbench/cfm_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module cfm_asserts #(
  parameter [31:0] VAL0_CYC = 32'h0000_0014,
  parameter [31:0] LL_WIN   = 32'h0000_03E8
)(
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [3:0]  clock_input_i,
  input wire logic [3:0]  clock_loss_flag_o,
  input wire logic [3:0]  lock_loss_flag_o,
  input wire logic [3:0]  alarm_pin_o,
  input wire logic        interrupt_out_n_o,
  input wire logic        irq_o
);
  logic [31:0] quiet_q;
  logic [31:0] clhi_q;
  logic [31:0] llhi_q;
  logic        ci0_q;
  wire         bad = (paddr_i >= 8'h50) || (paddr_i[1:0] != 2'b00) ||
                     (paddr_i[7:3] == 5'h03);

  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      quiet_q <= 32'h0000_0000;
      clhi_q  <= 32'h0000_0000;
      llhi_q  <= 32'h0000_0000;
      ci0_q   <= 1'b0;
    end
    else
    begin
      ci0_q   <= clock_input_i[0];
      quiet_q <= (ci0_q != clock_input_i[0]) ? 32'h0000_0000 : quiet_q + 1;
      clhi_q  <= clock_loss_flag_o[0] ? clhi_q + 1 : 32'h0000_0000;
      llhi_q  <= lock_loss_flag_o[0] ? llhi_q + 1 : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_access;
    psel_i && penable_i;
  endsequence
  sequence s_idle_out;
    clock_loss_flag_o == 4'h0 && lock_loss_flag_o == 4'h0 &&
    alarm_pin_o == 4'h0 && interrupt_out_n_o && !irq_o;
  endsequence

  a_ready_access: assert property (s_access |-> pready_o)
    else $error("pready low in access");
  a_err_unmapped: assert property (s_access ##0 bad |-> pslverr_o)
    else $error("no slave error on unmapped address");
  a_err_mapped: assert property (s_access ##0 !bad |-> !pslverr_o)
    else $error("slave error on mapped address");
  a_err_only_access: assert property (pslverr_o |-> s_access)
    else $error("slave error outside access");
  a_rdata_hold: assert property (!(psel_i && !penable_i) |=>
    $stable(prdata_o)) else $error("read data moved outside setup");
  a_reset_idle: assert property ($fell(rst_i) |-> s_idle_out)
    else $error("outputs not idle after reset");
  a_cl_quiet: assert property ($rose(clock_loss_flag_o[0]) |->
    quiet_q >= 8) else $error("clock loss with edges present");
  a_cl_val_time: assert property ($fell(clock_loss_flag_o[0]) |->
    clhi_q >= VAL0_CYC) else $error("clock loss cleared too early");
  a_ll_settle: assert property ($fell(lock_loss_flag_o[0]) |->
    llhi_q >= LL_WIN) else $error("lock loss cleared too early");
endmodule

bind cfm_clock_fault_monitor cfm_asserts #(
  .VAL0_CYC(VAL0_CYC), .LL_WIN(LL_WIN)) i_chk (
  .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o),
  .clock_input_i(clock_input_i), .clock_loss_flag_o(clock_loss_flag_o),
  .lock_loss_flag_o(lock_loss_flag_o), .alarm_pin_o(alarm_pin_o),
  .interrupt_out_n_o(interrupt_out_n_o), .irq_o(irq_o));
`default_nettype wire

// ==== testbench/cfm_clock_fault_monitor_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
  begin \
    n_tests = n_tests + 1; \
    if ((g) !== (e)) \
    begin \
      mismatches = mismatches + 1; \
      $display("mismatch at %0t got %h exp %h", $time, g, e); \
    end \
  end
module cfm_clock_fault_monitor_tb;
  logic        clock_i;
  logic        rst_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0]  run_q;
  logic [3:0]  fb_q;
  logic [31:0] rd;
  logic        err;
  wire  [31:0] prdata_o;
  wire         pready_o;
  wire         pslverr_o;
  wire  [3:0]  cin;
  wire  [3:0]  pref;
  wire  [3:0]  pfb;
  wire  [3:0]  clf;
  wire  [3:0]  llf;
  wire  [3:0]  alarm_pin_o;
  wire         interrupt_out_n_o;
  wire         irq_o;
  wire  [7:0]  flags = {llf, clf};
  int          mismatches;
  int          n_tests;
  int          seed;
  int          mirror [int];
  logic [7:0]  bad [3] = '{8'h18, 8'h50, 8'h06};
  logic [7:0]  rnd_a [3] = '{8'h48, 8'h4C, 8'h3C};
  logic [31:0] rnd_m [3] = '{32'h0000_00FF, 32'h0000_00FF, 32'hFFFF_FF3F};

  cfm_clock_fault_monitor #(.LL_WIN(32'h0000_03E8),
    .VAL0_CYC(32'h0000_0014), .VAL1_CYC(32'h0000_0028),
    .VAL2_CYC(32'h0000_003C), .VAL3_CYC(32'h0000_0050)) i_dut (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .clock_input_i(cin), .pll_ref_i(pref),
    .pll_fb_i(pfb), .clock_loss_flag_o(clf), .lock_loss_flag_o(llf),
    .alarm_pin_o(alarm_pin_o), .interrupt_out_n_o(interrupt_out_n_o),
    .irq_o(irq_o));

  cfm_far_side i_far (.clock_i(clock_i), .rst_i(rst_i), .run_i(run_q),
    .fb_run_i(fb_q), .clock_input_o(cin), .ref_o(pref), .fb_o(pfb));

  always #20 clock_i = ~clock_i;

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clock_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      @(posedge clock_i);
      while (pready_o !== 1'b1)
        @(posedge clock_i);
      rd  = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      if (w && mirror.exists(a))
        mirror[a] = d;
    end
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] e);
    begin
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rd, e)
    end
  endtask

  // The wait is bounded so that a stuck flag still reaches the compare.
  task wait_bit(input int i, input logic v, input int lim);
    int n;
    begin
      n = 0;
      while (flags[i] !== v && n < lim)
      begin
        @(posedge clock_i);
        n = n + 1;
      end
      `CHK(flags[i], v)
    end
  endtask

  task set_run(input logic [3:0] r, input logic [3:0] f);
    begin
      @(posedge clock_i);
      run_q <= r;
      fb_q  <= f;
    end
  endtask

  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  initial
  begin
    repeat (40000) @(posedge clock_i);
    mismatches = mismatches + 1;
    end_sim;
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    run_q = 4'hF;
    fb_q = 4'hF;
    seed = 32'h3695;
    mismatches = 0;
    n_tests = 0;
    mirror[8'h08] = 32'h0000_00FF;
    mirror[8'h0C] = 32'h0000_0000;
    mirror[8'h14] = 32'h0000_0000;
    mirror[8'h20] = 32'h0024_0040;
    mirror[8'h30] = 32'h0010_0036;
    mirror[8'h40] = 32'h0000_0000;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    foreach (mirror[k])
      rdchk(8'(k), 32'(mirror[k]));
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, bad[k], 32'hFFFF_FFFF);
      `CHK(err, 1'b1)
      rdchk(bad[k], 32'h0000_0000);
      mirror[rnd_a[k]] = 0;
      apb(1'b1, rnd_a[k], 32'($random(seed)) & rnd_m[k]);
      rdchk(rnd_a[k], 32'(mirror[rnd_a[k]]));
    end
    $display("test registers done");
    apb(1'b1, 8'h20, 32'h0012_0008);
    apb(1'b1, 8'h30, 32'h0000_1036);
    apb(1'b1, 8'h40, 32'h0000_0001);
    apb(1'b1, 8'h44, 32'h0000_0010);
    apb(1'b1, 8'h0C, 32'h0000_0001);
    apb(1'b1, 8'h14, 32'h0000_0001);
    set_run(4'hE, 4'hF);
    wait_bit(0, 1'b1, 300);
    `CHK(flags, 8'h01)
    repeat (3) @(posedge clock_i);
    rdchk(8'h00, 32'h0000_0001);
    `CHK({alarm_pin_o[1:0], interrupt_out_n_o, irq_o}, 4'b0101)
    apb(1'b1, 8'h04, 32'h0000_0001);
    rdchk(8'h04, 32'h0000_0001);
    rdchk(8'h10, 32'h0000_0001);
    repeat (3) @(posedge clock_i);
    `CHK(irq_o, 1'b0)
    set_run(4'hF, 4'hF);
    repeat (10) @(posedge clock_i);
    set_run(4'hE, 4'hF);
    repeat (12) @(posedge clock_i);
    set_run(4'hF, 4'hF);
    repeat (15) @(posedge clock_i);
    `CHK(flags[0], 1'b1)
    wait_bit(0, 1'b0, 300);
    rdchk(8'h04, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0000_0001);
    rdchk(8'h04, 32'h0000_0000);
    `CHK({alarm_pin_o[0], interrupt_out_n_o}, 2'b01)
    $display("test clock loss done");
    apb(1'b1, 8'h08, 32'h0000_00FE);
    apb(1'b1, 8'h14, 32'h0000_0000);
    set_run(4'hE, 4'hF);
    wait_bit(0, 1'b1, 300);
    repeat (3) @(posedge clock_i);
    rdchk(8'h04, 32'h0000_0000);
    `CHK({interrupt_out_n_o, irq_o}, 2'b10)
    rdchk(8'h10, 32'h0000_0001);
    set_run(4'hF, 4'hF);
    wait_bit(0, 1'b0, 300);
    apb(1'b1, 8'h08, 32'h0000_00FF);
    $display("test notify enable done");
    set_run(4'hF, 4'hE);
    wait_bit(4, 1'b1, 5000);
    repeat (3) @(posedge clock_i);
    rdchk(8'h00, 32'h0000_0010);
    rdchk(8'h04, 32'h0000_0010);
    `CHK(alarm_pin_o[1:0], 2'b10)
    set_run(4'hF, 4'hF);
    repeat (100) @(posedge clock_i);
    `CHK(flags[4], 1'b1)
    wait_bit(4, 1'b0, 7000);
    $display("test lock loss done");
    end_sim;
  end
endmodule
`default_nettype wire
